// >>> design/rfc_pkg.sv
// rfc_pkg: constants for the rtc flags/control and century register block.
// assumes an avalon-mm master that addresses each register by its offset.
package rfc_pkg;
	localparam int          ADDR_W          = 17;
	localparam logic [16:0] OFS_FLAGS       = 17'h1fff0;
	localparam logic [16:0] OFS_CENTURY     = 17'h1fff1;
	// the slave is addressed by register offset; the extra registers sit low
	localparam logic [16:0] ADR_FLAGS       = OFS_FLAGS;
	localparam logic [16:0] ADR_CENTURY     = OFS_CENTURY;
	localparam logic [16:0] ADR_IRQ_STATUS  = 17'h00000;
	localparam logic [16:0] ADR_IRQ_MASK    = 17'h00004;
	localparam logic [16:0] ADR_USER_TIME   = 17'h00008;
	// flags register fields
	localparam int          BIT_WDOG        = 7;
	localparam int          BIT_ALARM       = 6;
	localparam int          BIT_PWR         = 5;
	localparam int          BIT_OSC         = 4;
	localparam int          BIT_CAL         = 2;
	localparam int          BIT_WLOCK       = 1;
	localparam int          BIT_RFRZ        = 0;
	localparam logic [7:0]  CENTURY_RST     = 8'h00;
	localparam logic [3:0]  BCD_MAX         = 4'h9;
	// timing
	localparam int          CLK_HZ          = 25000000;
	localparam int          CAL_HZ          = 512;
	localparam int          CAL_HALF        = CLK_HZ / (2 * CAL_HZ);
	localparam logic [15:0] CAL_HALF_CNT    = 16'(CAL_HALF - 1);
endpackage

// >>> design/rfc_top.sv
// rfc_top: flags/control and century registers of an embedded rtc.
// assumes event pulses come from the rtc core on CORE_CLK_IN; oscillator fail
// and power fail are pin levels and are synchronised here.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module rfc_top
	import rfc_pkg::*;
(
	// clock and reset
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RST_N_IN,
	// avalon-mm slave
	input  wire logic [16:0] AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic      [31:0] AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	// rtc core events and time
	input  wire logic        WATCHDOG_EXPIRE_IN,
	input  wire logic        ALARM_MATCH_IN,
	input  wire logic        POWER_FAIL_IN,
	input  wire logic        OSC_FAIL_IN,
	input  wire logic [31:0] COUNTER_TIME_IN,
	// control outputs
	output logic             WRITE_LOCK_OUT,
	output logic             INT_OUT,
	output logic             INT_OE_OUT
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// both pins are asynchronous levels; nothing but the second stage is read
	wire  [1:0] pin_raw = {POWER_FAIL_IN, OSC_FAIL_IN};
	wire  [1:0] pin_lvl;
	wire        pwr_low_lvl;
	wire        osc_stop_lvl;
	for (genvar p = 0; p < $bits(pin_raw); p++) begin : g_pin_sync
		logic [1:0] stage_q;
		always_ff @(posedge CORE_CLK_IN) begin
			if (!RST_N_IN) begin
				stage_q <= 2'h0;
			end else begin
				stage_q <= {stage_q[0], pin_raw[p]};
			end
		end
		assign pin_lvl[p] = stage_q[1];
	end
	assign {pwr_low_lvl, osc_stop_lvl} = pin_lvl;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// waitrequest rests high and drops for one cycle per access; gating the
	// strobes with it takes a held request exactly once
	wire        req       = (AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT;
	wire        wr        = AVS_WRITE_IN & AVS_WAITREQUEST_OUT & AVS_BYTEENABLE_IN[0];
	wire        rd        = AVS_READ_IN & AVS_WAITREQUEST_OUT;
	wire        sel_flags = AVS_ADDRESS_IN == ADR_FLAGS;
	wire        sel_cent  = AVS_ADDRESS_IN == ADR_CENTURY;
	wire        sel_ist   = AVS_ADDRESS_IN == ADR_IRQ_STATUS;
	wire        sel_imk   = AVS_ADDRESS_IN == ADR_IRQ_MASK;
	wire        sel_time  = AVS_ADDRESS_IN == ADR_USER_TIME;
	wire        wr_flags  = wr & sel_flags;
	wire        rd_flags  = rd & sel_flags;
	wire [7:0]  wdat      = AVS_WRITEDATA_IN[7:0];

	// ----------------------------------------------------------------
	// flags and control
	// ----------------------------------------------------------------
	logic        wdog_flag_q;
	logic        alarm_flag_q;
	logic        pwr_flag_q;
	logic        osc_flag_q;
	logic        cal_q;
	logic        wlock_q;
	logic        rfrz_q;
	logic [7:0]  century_q;
	logic [7:0]  ist_q;
	logic [7:0]  imask_q;
	logic [31:0] user_time_q;
	// events win over a clearing read in the same cycle
	wire         wdog_flag_d  = WATCHDOG_EXPIRE_IN | (wdog_flag_q & ~rd_flags);
	wire         alarm_flag_d = ALARM_MATCH_IN | (alarm_flag_q & ~rd_flags);
	wire         pwr_flag_d   = pwr_low_lvl | (pwr_flag_q & ~rd_flags);
	// a read leaves the oscillator flag alone: only a written zero clears it,
	// so software cannot lose the sign that the time is no longer valid
	wire         osc_flag_d   = osc_stop_lvl | (osc_flag_q & ~(wr_flags & ~wdat[BIT_OSC]));
	logic [7:0]  flags_rd;
	always_comb begin
		flags_rd            = 8'h00;
		flags_rd[BIT_WDOG]  = wdog_flag_q;
		flags_rd[BIT_ALARM] = alarm_flag_q;
		flags_rd[BIT_PWR]   = pwr_flag_q;
		flags_rd[BIT_OSC]   = osc_flag_q;
		flags_rd[BIT_CAL]   = cal_q;
		flags_rd[BIT_WLOCK] = wlock_q;
		flags_rd[BIT_RFRZ]  = rfrz_q;
	end

	// digits above nine are clamped so the register never holds a non-bcd code
	localparam int DIG_W = $bits(BCD_MAX);
	wire [7:0]  cen_wr;
	for (genvar d = 0; d < $bits(cen_wr) / DIG_W; d++) begin : g_bcd_clamp
		wire [DIG_W-1:0] digit     = wdat[d * DIG_W +: DIG_W];
		wire [DIG_W-1:0] digit_sat = (digit > BCD_MAX) ? BCD_MAX : digit;
		assign cen_wr[d * DIG_W +: DIG_W] = digit_sat;
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			wdog_flag_q  <= 1'b0;
			alarm_flag_q <= 1'b0;
			pwr_flag_q   <= 1'b0;
			osc_flag_q   <= 1'b0;
			cal_q        <= 1'b0;
			wlock_q      <= 1'b0;
			rfrz_q       <= 1'b0;
		end else begin
			wdog_flag_q  <= wdog_flag_d;
			alarm_flag_q <= alarm_flag_d;
			pwr_flag_q   <= pwr_flag_d;
			osc_flag_q   <= osc_flag_d;
			if (wr_flags) begin
				cal_q   <= wdat[BIT_CAL];
				wlock_q <= wdat[BIT_WLOCK];
				rfrz_q  <= wdat[BIT_RFRZ];
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			century_q <= CENTURY_RST;
		end else if (wr && sel_cent) begin
			century_q <= cen_wr;
		end
	end

	// user copy freezes while read-freeze is set
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			user_time_q <= 32'h0;
		end else if (!rfrz_q) begin
			user_time_q <= COUNTER_TIME_IN;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	logic [7:0] ev;
	always_comb begin
		ev            = 8'h00;
		ev[BIT_WDOG]  = WATCHDOG_EXPIRE_IN;
		ev[BIT_ALARM] = ALARM_MATCH_IN;
		ev[BIT_PWR]   = pwr_low_lvl;
		ev[BIT_OSC]   = osc_stop_lvl;
	end
	// write one to clear; an event in the same cycle keeps its bit set
	wire [7:0]  iclr  = (wr && sel_ist) ? wdat : 8'h00;
	wire [7:0]  ist_d = ev | (ist_q & ~iclr);
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			ist_q   <= 8'h00;
			imask_q <= 8'h00;
		end else begin
			ist_q <= ist_d;
			if (wr && sel_imk) begin
				imask_q <= wdat;
			end
		end
	end
	// next-state view, so the pin follows a set or clear without an extra cycle
	wire irq_lvl = |(ist_d & imask_q);

	// ----------------------------------------------------------------
	// calibration square wave
	// ----------------------------------------------------------------
	// the half period is rounded down, so the wave runs a hair fast
	logic [15:0] cal_cnt_q;
	logic        cal_wave_q;
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN || !cal_q) begin
			cal_cnt_q  <= 16'h0;
			cal_wave_q <= 1'b0;
		end else if (cal_cnt_q == CAL_HALF_CNT) begin
			cal_cnt_q  <= 16'h0;
			cal_wave_q <= ~cal_wave_q;
		end else begin
			cal_cnt_q <= cal_cnt_q + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// bus answer and outputs
	// ----------------------------------------------------------------
	wire [7:0] rd_mux = sel_flags ? flags_rd :
	                    sel_cent  ? century_q :
	                    sel_ist   ? ist_q :
	                    sel_imk   ? imask_q : 8'h00;
	wire [31:0] rd_word = sel_time ? user_time_q : {24'h0, rd_mux};

	// the pin is open drain: it is only ever pulled low, never driven high
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			AVS_WAITREQUEST_OUT <= 1'b1;
			AVS_READDATA_OUT    <= 32'h0;
			INT_OUT             <= 1'b0;
			INT_OE_OUT          <= 1'b0;
			WRITE_LOCK_OUT      <= 1'b0;
		end else begin
			AVS_WAITREQUEST_OUT <= ~req;
			WRITE_LOCK_OUT      <= wlock_q;
			if (rd) begin
				AVS_READDATA_OUT <= rd_word;
			end
			if (cal_q) begin
				INT_OUT    <= cal_wave_q;
				INT_OE_OUT <= ~cal_wave_q;
			end else begin
				INT_OUT    <= 1'b0;
				INT_OE_OUT <= irq_lvl;
			end
		end
	end

endmodule // rfc_top

// >>> testbench/rfc_props.sv
// rfc_props: port-level checks for rfc_top
// assumes one clock domain; bound to rfc_top below
`timescale 1ns/1ns
module rfc_props
	import rfc_pkg::*;
(
	// watched ports
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_N_IN,
	input wire logic [16:0] AVS_ADDRESS_IN,
	input wire logic        AVS_READ_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic        AVS_WAITREQUEST_OUT,
	input wire logic        INT_OUT,
	input wire logic        INT_OE_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence ans_s;
		!AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
	endsequence
	reset_quiet_a: assert property ($rose(RST_N_IN) |-> !INT_OE_OUT && AVS_WAITREQUEST_OUT)
		else $error("pin driven or bus busy after reset");
	drain_only_a: assert property (INT_OE_OUT |-> !INT_OUT)
		else $error("pin driven high");
	wave_hold_a: assert property ($changed(INT_OE_OUT) |=> $stable(INT_OE_OUT)[*8])
		else $error("pin toggles too fast");
	bus_answer_a: assert property ($rose(AVS_READ_IN) |=> ans_s)
		else $error("read answer late");
	century_bcd_a: assert property (AVS_READ_IN && !AVS_WAITREQUEST_OUT
		&& AVS_ADDRESS_IN == ADR_CENTURY |-> AVS_READDATA_OUT[3:0] <= 4'h9
		&& AVS_READDATA_OUT[7:4] <= 4'h9) else $error("century not bcd");
endmodule // rfc_props
bind rfc_top rfc_props i_rfc_props (.CORE_CLK_IN, .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN,
	.AVS_READDATA_OUT, .AVS_WAITREQUEST_OUT, .INT_OUT, .INT_OE_OUT);

// >>> testbench/tb.sv
// tb: self-checking bench for rfc_top
// assumes the checker file is compiled alongside
`timescale 1ns/1ns
module tb;
	import rfc_pkg::*;
	logic        clk = 0, rst_n = 0, rd = 0, wr = 0, alarm = 0, wq, oe, wlk;
	logic [16:0] adr = '0;
	logic [31:0] wd = '0, tim = 32'h1234, rdat, q;
	int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
	rfc_top i_rfc_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'h1), .AVS_READDATA_OUT(rdat),
		.AVS_WAITREQUEST_OUT(wq), .WATCHDOG_EXPIRE_IN(1'b0), .ALARM_MATCH_IN(alarm),
		.POWER_FAIL_IN(1'b0), .OSC_FAIL_IN(1'b0), .COUNTER_TIME_IN(tim), .WRITE_LOCK_OUT(wlk),
		.INT_OUT(), .INT_OE_OUT(oe));
	initial forever #20 clk = ~clk;
	// one half wave period, waited out by the second flip, dominates the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input bit w, input logic [16:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h0, d};
		do @(posedge clk); while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic flip();
		logic o;
		o = oe;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (oe === o && n < 30000);
	endtask
	task automatic t_reset();
		bus(0, ADR_FLAGS, 8'h00);
		chk(q & 32'h7, 32'h0);
		chk(wlk, 1'b0);
		bus(1, ADR_FLAGS, 8'h02);
		repeat (2) @(posedge clk);
		chk(wlk, 1'b1);
		bus(1, ADR_FLAGS, 8'h00);
	endtask
	task automatic t_century();
		bus(1, ADR_CENTURY, 8'h59);
		bus(0, ADR_CENTURY, 8'h00);
		chk(q, 32'h59);
		bus(1, ADR_CENTURY, 8'h3f);
		bus(0, ADR_CENTURY, 8'h00);
		chk(q, 32'h39);
	endtask
	task automatic t_cal();
		bus(1, ADR_FLAGS, 8'h04);
		flip();
		flip();
		chk(32'(n), 32'(CAL_HALF));
		repeat (10) @(posedge clk);
		alarm <= 1'b1;
		@(posedge clk);
		alarm <= 1'b0;
		bus(1, ADR_FLAGS, 8'h00);
		repeat (3) @(posedge clk);
		chk(oe, 1'b1);
	endtask
	task automatic t_irq();
		alarm <= 1'b1;
		@(posedge clk);
		alarm <= 1'b0;
		repeat (10) @(posedge clk);
		chk(oe, 1'b0);
		bus(0, ADR_FLAGS, 8'h00);
		chk(q, 32'h40);
		bus(0, ADR_FLAGS, 8'h00);
		chk(q, 32'h0);
		bus(1, ADR_IRQ_MASK, 8'h40);
		repeat (10) @(posedge clk);
		chk(oe, 1'b1);
		bus(1, ADR_IRQ_STATUS, 8'h40);
		repeat (3) @(posedge clk);
		chk(oe, 1'b0);
		bus(0, 17'h00100, 8'h00);
		chk(q, 32'h0);
	endtask
	task automatic t_freeze();
		bus(1, ADR_FLAGS, 8'h01);
		tim <= 32'h5678;
		repeat (3) @(posedge clk);
		bus(0, ADR_USER_TIME, 8'h00);
		chk(q, 32'h1234);
		bus(1, ADR_FLAGS, 8'h00);
		bus(0, ADR_USER_TIME, 8'h00);
		chk(q, 32'h5678);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_century();
		t_freeze();
		t_irq();
		t_cal();
		tally_and_finish();
	end
endmodule // tb
